/* mic_assertions.sv */
/* Port checker of the motion interrupt controller.
   Assumes one clock domain and the bind below. */
`timescale 1ns/1ps
module mic_assertions (
  // Clock and reset
  input logic clk,
  input logic rst_b,
  // Inputs
  input logic sampleValid,
  input logic tapEvent,
  input logic [2:0] tapAxis,
  input logic regRead,
  input logic [6:0] regAddr,
  input logic lowPowerMode,
  input logic awakeDone,
  // Outputs
  input logic [7:0] regRdata,
  input logic intOut,
  input logic ctrlEnable,
  input logic sleepReq,
  input logic [2:0] knockOrigin
);
  // ***
  // Properties
  // ***
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Four edges cover the two-flop pin sync plus the output flop
  sequence lpAsleep;
    (lowPowerMode && !awakeDone) [*4];
  endsequence
  sequence riseCause;
    $past(sampleValid) || $past(sampleValid, 2) || $past(tapEvent) || $past(tapEvent, 2);
  endsequence
  AST_RDATA_HOLD: assert property (!regRead |=> $stable(regRdata))
    else $error("read data moved without a read");
  AST_UNMAPPED_ZERO: assert property (regRead && regAddr == 7'h20 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  AST_NORMAL_ON: assert property (!lowPowerMode [*4] |-> ctrlEnable)
    else $error("controller off in normal mode");
  AST_LP_OFF: assert property (lpAsleep |-> !ctrlEnable)
    else $error("controller on before wake");
  AST_LP_ON: assert property (awakeDone [*2] |-> ctrlEnable)
    else $error("controller off while awake");
  AST_STAY_AWAKE: assert property (intOut [*2] |-> !sleepReq)
    else $error("sleep asked during interrupt");
  AST_KNOCK_CAPTURE: assert property (tapEvent |=> knockOrigin == $past(tapAxis))
    else $error("tap axes not stored");
  AST_RISE_CAUSE: assert property ($rose(intOut) |-> riseCause)
    else $error("interrupt rose without cause");
endmodule
bind mic_motion_interrupt_controller mic_assertions chk_u (.clk(clk), .rst_b(rst_b),
  .sampleValid(sampleValid), .tapEvent(tapEvent), .tapAxis(tapAxis), .regRead(regRead),
  .regAddr(regAddr), .lowPowerMode(lowPowerMode), .awakeDone(awakeDone),
  .regRdata(regRdata), .intOut(intOut), .ctrlEnable(ctrlEnable), .sleepReq(sleepReq),
  .knockOrigin(knockOrigin));

/* mic_defs.vh */
/*
 * Register offsets, field positions, reset values and timing counts
 * for the motion interrupt controller.
 * Assumes a 200 MHz core clock and a byte-wide register port.
 */
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define MIC_OFS_SLOPE_CFG 7'h09
`define MIC_OFS_INT_STATUS 7'h0C
`define MIC_OFS_AXIS_EN 7'h0D
`define MIC_OFS_LATCH_CFG 7'h0E

// ****************************************
// Field positions and reset values
// ****************************************
`define MIC_SLOPE_FILT_BIT 6
`define MIC_MOTION_THR_HI 5
`define MIC_MOTION_THR_LO 2
`define MIC_PTS_HI 1
`define MIC_PTS_LO 0
`define MIC_SLOPE_CFG_RST 8'h45
`define MIC_AXIS_EN_X 5
`define MIC_AXIS_EN_Y 4
`define MIC_AXIS_EN_Z 3
`define MIC_AXIS_EN_RST 8'h00
`define MIC_ST_SLOPE_BIT 0
`define MIC_ST_TAP_BIT 4
`define MIC_LATCH_RST_BIT 7
`define MIC_LAT_NONE 3'h0
`define MIC_LAT_PERM 3'h7

// ****************************************
// Timing
// ****************************************
`define MIC_CLK_MHZ 200
`define MIC_LAT_BASE_MS 250
`define MIC_LAT_BASE_CYC (`MIC_LAT_BASE_MS * 1000 * `MIC_CLK_MHZ)

`endif

/* mic_host_model.sv */
/* Host model on the byte register port.
   Assumes strobes launched on the falling edge are taken on the next rise. */
`timescale 1ns/1ps
module mic_host_model (
  // Clock
  input logic clk,
  // Register port
  output logic regWrite,
  output logic regRead,
  output logic [6:0] regAddr,
  output logic [7:0] regWdata,
  input logic [7:0] regRdata
);
  // ***
  // Bus tasks
  // ***
  // Idle bus shows inverted values so a stale copy is never trusted
  initial begin
    {regWrite, regRead, regAddr, regWdata} = 17'h07FFF;
  end
  // One byte write
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    {regWrite, regAddr, regWdata} = {1'b1, a, d};
    @(negedge clk);
    {regWrite, regAddr, regWdata} = {1'b0, ~a, ~d};
  endtask
  // One byte read, data stands the cycle after the read edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    {regRead, regAddr} = {1'b1, a};
    @(negedge clk);
    d = regRdata;
    {regRead, regAddr} = {1'b0, ~a};
  endtask
  // Restart after any setup change, which also clears a held output
  task automatic restart(input logic [2:0] lat);
    wr(7'h0E, {5'h10, lat});
    repeat (2) @(negedge clk);
  endtask
endmodule

/* mic_motion_interrupt_controller.v */
/*
 * Motion interrupt controller: any-motion slope engine, latch timer,
 * interrupt status and the power manager's awake/sleep handshake.
 * Assumes samples arrive with a one-cycle strobe from the sensor data path
 * in this clock domain, and a simple byte register port from the serial
 * interface logic in the same domain. Pins wakeMode and lowPowerMode are
 * pad straps and pass two flip-flops.
 */
// Functional notes
// - Interrupt output goes high while any configured condition holds.
// - Status registers hold fired interrupt type and triggering axes.
// - Latched mode keeps output high until host clears it.
// - Unlatched mode drops output as soon as condition ends.
// - Latch field: 000 unlatched, 111 permanent, others 0.25s to 8s.
// - Low-power mode wakes, evaluates, sleeps unless interrupt is present.
// - Normal mode keeps controller enabled and processing every sample.
// - Power manager enables controller after wake; sleeps when all engines idle.
// - Slope is difference of two successive samples.
// - Any-motion fires after duration points above threshold on enabled axis.
// - Any-motion clears after duration points all below, unless latched.
// - First-axis flags and sign flag report any-motion cause.
// - Engine runs when any axis enable set; stops when all clear.
// - Wake-up mode evaluates all three axes regardless of enables.
// - Axis enables x,y,z at bits 5,4,3, reset zero.
// - Threshold bits 5..2, one data LSB per step, reset 0001.
// - Duration bits 1..0 give 1..4 points, reset 01.
// - Filter select bit 6: 0 unfiltered, 1 filtered, reset 1.
// - Slope status at status bit 0, reset zero.
// - Sign flag zero positive, one negative, reset zero.
// - Tap axis flags and direction stored in readable registers; here they only drive the knockOrigin and knockDirection outputs.
`timescale 1ns/1ps
`include "mic_defs.vh"

module mic_motion_interrupt_controller #(
  parameter LAT_BASE_CYC = `MIC_LAT_BASE_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Sample stream, two's complement 6-bit per axis
  input wire sampleValid,
  input wire [5:0] accFiltX,
  input wire [5:0] accFiltY,
  input wire [5:0] accFiltZ,
  input wire [5:0] accRawX,
  input wire [5:0] accRawY,
  input wire [5:0] accRawZ,
  // Tap engine results (engine lives elsewhere)
  input wire tapEvent,
  input wire [2:0] tapAxis,
  input wire tapSign,
  // Mode pins
  input wire lowPowerMode,
  input wire wakeMode,
  // Power manager handshake
  input wire awakeDone,
  // Register port
  input wire regWrite,
  input wire regRead,
  input wire [6:0] regAddr,
  input wire [7:0] regWdata,
  // Outputs
  output reg [7:0] regRdata,
  output reg intOut,
  output reg ctrlEnable,
  output reg sleepReq,
  output reg [2:0] knockOrigin,
  output reg knockDirection
);

  // ****************************************
  // Helpers
  // ****************************************
  // Magnitude of a signed 7-bit slope
  function [6:0] micAbs;
    input [6:0] v;
    begin
      micAbs = v[6] ? (7'h00 - v) : v;
    end
  endfunction

  // Latch time in base periods for codes 001..110
  function [5:0] micLatMult;
    input [2:0] code;
    begin
      micLatMult = 6'h01 << (code - 3'h1);
    end
  endfunction

  // ****************************************
  // Registers and synchronisers
  // ****************************************
  reg [7:0] slopeCfg_q;
  reg [7:0] axisEn_q;
  reg [2:0] latCode_q;
  reg ctrlRstPulse_q;
  reg [1:0] lpSync_q;
  reg [1:0] wkSync_q;
  reg [5:0] prevX_q, prevY_q, prevZ_q;
  reg havePrev_q;
  reg [2:0] aboveCnt_q, belowCnt_q;
  reg slopeCond_q;
  reg slopeSt_q;
  reg [2:0] slopeFirst_q;
  reg slopeSign_q;
  reg tapSt_q;
  reg latched_q;
  reg [31:0] latCnt_q;
  reg [5:0] latUnits_q;

  wire lowPower = lpSync_q[1];
  wire wakeAll = wkSync_q[1];

  // Pad straps pass two flops before use
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lpSync_q <= 2'h0;
      wkSync_q <= 2'h0;
    end else begin
      lpSync_q <= {lpSync_q[0], lowPowerMode};
      wkSync_q <= {wkSync_q[0], wakeMode};
    end
  end

  // ****************************************
  // Slope engine
  // ****************************************
  wire [2:0] axisEnEff = wakeAll ? 3'h7 : {axisEn_q[`MIC_AXIS_EN_X],
    axisEn_q[`MIC_AXIS_EN_Y], axisEn_q[`MIC_AXIS_EN_Z]};
  wire useFilt = slopeCfg_q[`MIC_SLOPE_FILT_BIT];
  wire [5:0] curX = useFilt ? accFiltX : accRawX;
  wire [5:0] curY = useFilt ? accFiltY : accRawY;
  wire [5:0] curZ = useFilt ? accFiltZ : accRawZ;
  // Sign-extended difference of successive samples
  wire [6:0] dX = {curX[5], curX} - {prevX_q[5], prevX_q};
  wire [6:0] dY = {curY[5], curY} - {prevY_q[5], prevY_q};
  wire [6:0] dZ = {curZ[5], curZ} - {prevZ_q[5], prevZ_q};
  wire [6:0] thr = {3'h0, slopeCfg_q[`MIC_MOTION_THR_HI:`MIC_MOTION_THR_LO]};
  wire [2:0] need = {1'b0, slopeCfg_q[`MIC_PTS_HI:`MIC_PTS_LO]} + 3'h1;
  wire [2:0] over = {micAbs(dX) > thr, micAbs(dY) > thr, micAbs(dZ) > thr} & axisEnEff;
  wire engineOn = (axisEnEff != 3'h0) && ctrlEnable;
  wire evalNow = sampleValid && engineOn && havePrev_q;
  wire anyOver = over != 3'h0;
  wire slopeFire = evalNow && anyOver && !slopeCond_q && (aboveCnt_q + 3'h1 >= need);
  wire slopeDrop = evalNow && !anyOver && slopeCond_q && (belowCnt_q + 3'h1 >= need);
  // Sign of the first triggering axis, taken in x, y, z priority
  wire trigSign = over[2] ? dX[6] : (over[1] ? dY[6] : dZ[6]);

  // Sample history and consecutive point counters; controller reset restarts them
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prevX_q <= 6'h00;
      prevY_q <= 6'h00;
      prevZ_q <= 6'h00;
      havePrev_q <= 1'b0;
      aboveCnt_q <= 3'h0;
      belowCnt_q <= 3'h0;
      slopeCond_q <= 1'b0;
    end else if (ctrlRstPulse_q || !engineOn) begin
      havePrev_q <= 1'b0;
      aboveCnt_q <= 3'h0;
      belowCnt_q <= 3'h0;
      slopeCond_q <= 1'b0;
    end else if (sampleValid) begin
      prevX_q <= curX;
      prevY_q <= curY;
      prevZ_q <= curZ;
      havePrev_q <= 1'b1;
      if (havePrev_q) begin
        // Counters saturate so a long run never wraps back below need
        aboveCnt_q <= anyOver ? (aboveCnt_q == 3'h4 ? 3'h4 : aboveCnt_q + 3'h1) : 3'h0;
        belowCnt_q <= anyOver ? 3'h0 : (belowCnt_q == 3'h4 ? 3'h4 : belowCnt_q + 3'h1);
        if (slopeFire) begin
          slopeCond_q <= 1'b1;
        end else if (slopeDrop) begin
          slopeCond_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Status, cause flags and latch
  // ****************************************
  wire anyCond = slopeCond_q;
  wire latchTimed = (latCode_q != `MIC_LAT_NONE) && (latCode_q != `MIC_LAT_PERM);
  wire latchAny = latCode_q != `MIC_LAT_NONE;
  wire statusRead = regRead && (regAddr == `MIC_OFS_INT_STATUS);
  wire latTimeout = latchTimed && latched_q && (latCnt_q == LAT_BASE_CYC - 1)
    && (latUnits_q == micLatMult(latCode_q) - 6'h01);

  // Status and sticky cause; a new event wins over a clear: tap status on a status read, slope status on a controller reset
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slopeSt_q <= 1'b0;
      slopeFirst_q <= 3'h0;
      slopeSign_q <= 1'b0;
      tapSt_q <= 1'b0;
      knockOrigin <= 3'h0;
      knockDirection <= 1'b0;
    end else begin
      if (slopeFire) begin
        slopeSt_q <= 1'b1;
        slopeFirst_q <= over;
        slopeSign_q <= trigSign;
      end else if (ctrlRstPulse_q || (!latchAny && slopeDrop)) begin
        slopeSt_q <= 1'b0;
      end
      if (tapEvent) begin
        tapSt_q <= 1'b1;
        knockOrigin <= tapAxis;
        knockDirection <= tapSign;
      end else if (ctrlRstPulse_q || statusRead) begin
        tapSt_q <= 1'b0;
      end
    end
  end

  // Output latch and timer; a fresh assertion restarts the timer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latched_q <= 1'b0;
      latCnt_q <= 32'h00000000;
      latUnits_q <= 6'h00;
      intOut <= 1'b0;
    end else begin
      if (slopeFire || tapEvent) begin
        latched_q <= latchAny;
        latCnt_q <= 32'h00000000;
        latUnits_q <= 6'h00;
      end else if (ctrlRstPulse_q || latTimeout) begin
        latched_q <= 1'b0;
      end else if (latched_q && latchTimed) begin
        if (latCnt_q == LAT_BASE_CYC - 1) begin
          latCnt_q <= 32'h00000000;
          latUnits_q <= latUnits_q + 6'h01;
        end else begin
          latCnt_q <= latCnt_q + 32'h00000001;
        end
      end
      // Unlatched mode follows the live condition
      intOut <= anyCond || tapEvent || (latched_q && !latTimeout && !ctrlRstPulse_q);
    end
  end

  // ****************************************
  // Power manager handshake
  // ****************************************
  // Controller is always on in normal mode; in low power only once awake
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlEnable <= 1'b0;
      sleepReq <= 1'b0;
    end else begin
      ctrlEnable <= !lowPower || awakeDone;
      // Sleep once the engine has seen a sample, or is off, and nothing holds
      sleepReq <= lowPower && awakeDone && (havePrev_q || !engineOn)
        && !anyCond && !latched_q && !intOut;
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  // Writes; the controller reset bit self-clears after one cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slopeCfg_q <= `MIC_SLOPE_CFG_RST;
      axisEn_q <= `MIC_AXIS_EN_RST;
      latCode_q <= `MIC_LAT_NONE;
      ctrlRstPulse_q <= 1'b0;
    end else begin
      ctrlRstPulse_q <= 1'b0;
      if (regWrite) begin
        if (regAddr == `MIC_OFS_SLOPE_CFG) begin
          slopeCfg_q <= {1'b0, regWdata[6:0]};
        end else if (regAddr == `MIC_OFS_AXIS_EN) begin
          axisEn_q <= regWdata;
        end else if (regAddr == `MIC_OFS_LATCH_CFG) begin
          latCode_q <= regWdata[2:0];
          ctrlRstPulse_q <= regWdata[`MIC_LATCH_RST_BIT];
        end
      end
    end
  end

  // Read data registered one cycle after the strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      if (regAddr == `MIC_OFS_SLOPE_CFG) begin
        regRdata <= slopeCfg_q;
      end else if (regAddr == `MIC_OFS_INT_STATUS) begin
        regRdata <= {slopeSign_q, slopeFirst_q, tapSt_q, 2'h0, slopeSt_q};
      end else if (regAddr == `MIC_OFS_AXIS_EN) begin
        regRdata <= axisEn_q;
      end else if (regAddr == `MIC_OFS_LATCH_CFG) begin
        regRdata <= {5'h00, latCode_q};
      end else begin
        regRdata <= 8'h00;
      end
    end
  end

endmodule

/* tb_motion_interrupt_controller.sv */
/* Testbench of the motion interrupt controller with host model.
   Assumes a 200 MHz clock and a short latch base of 20 cycles. */
`timescale 1ns/1ps
module tb_motion_interrupt_controller;
  // ***
  // Bench
  // ***
  logic clk, rst_b, sampleValid, tapEvent, tapSign, lowPowerMode, wakeMode, awakeDone;
  logic regWrite, regRead, intOut, ctrlEnable, sleepReq, knockDirection;
  logic [5:0] fx, fy, fz, rx, ry, rz;
  logic [6:0] regAddr;
  logic [7:0] regWdata, regRdata, rdVal;
  logic [2:0] tapAxis, knockOrigin;
  int failures = 0, cmp_count = 0, cycles = 0, n;
  // Design with a short latch base, and the host
  mic_motion_interrupt_controller #(.LAT_BASE_CYC(20)) dut_u (.clk(clk), .rst_b(rst_b),
    .sampleValid(sampleValid), .accFiltX(fx), .accFiltY(fy), .accFiltZ(fz), .accRawX(rx),
    .accRawY(ry), .accRawZ(rz), .tapEvent(tapEvent), .tapAxis(tapAxis), .tapSign(tapSign),
    .lowPowerMode(lowPowerMode), .wakeMode(wakeMode), .awakeDone(awakeDone),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .intOut(intOut), .ctrlEnable(ctrlEnable), .sleepReq(sleepReq),
    .knockOrigin(knockOrigin), .knockDirection(knockDirection));
  mic_host_model host_u (.clk(clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic cf(input logic s, input logic e);
    chk({7'h00, s}, {7'h00, e});
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    host_u.rd(a, rdVal);
    chk(rdVal, e);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One sample set, then settling time for the output
  task automatic smp(input logic [5:0] x, input logic [5:0] y, input logic [5:0] r);
    @(negedge clk);
    {fx, fy, rx, sampleValid} = {x, y, r, 1'b1};
    @(negedge clk);
    sampleValid = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // Setup, restart and a priming sample
  task automatic cfg(input logic [2:0] lat, input logic [7:0] sc);
    host_u.wr(7'h09, sc);
    host_u.wr(7'h0D, 8'h20);
    host_u.restart(lat);
    smp(6'h00, 6'h00, 6'h00);
  endtask
  // Unlatched rise and fall, cause flags, sign and tap capture
  task automatic t_basic();
    cfg(3'h0, 8'h48);
    rc(7'h09, 8'h48);
    rc(7'h0D, 8'h20);
    // A slope equal to the threshold must not count
    smp(6'h02, 6'h00, 6'h00);
    cf(intOut, 1'b0);
    smp(6'h07, 6'h00, 6'h00);
    cf(intOut, 1'b1);
    rc(7'h0C, 8'h41);
    smp(6'h07, 6'h00, 6'h00);
    cf(intOut, 1'b0);
    smp(6'h02, 6'h00, 6'h00);
    rc(7'h0C, 8'hC1);
    {tapAxis, tapSign, tapEvent} = 5'h0B;
    @(negedge clk);
    tapEvent = 1'b0;
    @(negedge clk);
    chk({4'h0, knockOrigin, knockDirection}, 8'h05);
    // Tap status shows once, then the status read clears it
    rc(7'h0C, 8'hC9);
    rc(7'h0C, 8'hC1);
  endtask
  // Two points to fire, two to clear; filter select; axis enables
  task automatic t_dur();
    cfg(3'h0, 8'h49);
    smp(6'h05, 6'h00, 6'h00);
    cf(intOut, 1'b0);
    smp(6'h0A, 6'h00, 6'h00);
    cf(intOut, 1'b1);
    smp(6'h0A, 6'h00, 6'h00);
    cf(intOut, 1'b1);
    smp(6'h0A, 6'h00, 6'h00);
    cf(intOut, 1'b0);
    cfg(3'h0, 8'h08);
    smp(6'h09, 6'h00, 6'h00);
    cf(intOut, 1'b0);
    smp(6'h09, 6'h00, 6'h05);
    cf(intOut, 1'b1);
    cfg(3'h0, 8'h48);
    smp(6'h00, 6'h09, 6'h00);
    cf(intOut, 1'b0);
    wakeMode = 1'b1;
    repeat (3) @(negedge clk);
    smp(6'h00, 6'h12, 6'h00);
    cf(intOut, 1'b1);
    wakeMode = 1'b0;
  endtask
  // Permanent and timed latching
  task automatic t_latch();
    cfg(3'h7, 8'h48);
    smp(6'h05, 6'h00, 6'h00);
    smp(6'h05, 6'h00, 6'h00);
    smp(6'h05, 6'h00, 6'h00);
    cf(intOut, 1'b1);
    host_u.restart(3'h7);
    cf(intOut, 1'b0);
    cfg(3'h1, 8'h48);
    smp(6'h05, 6'h00, 6'h00);
    cf(intOut, 1'b1);
    smp(6'h05, 6'h00, 6'h00);
    n = 0;
    while (intOut === 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    cf(n >= 8 && n <= 18, 1'b1);
    rc(7'h0E, 8'h01);
  endtask
  // Low-power wake, sleep request and return to normal mode
  task automatic t_power();
    cfg(3'h0, 8'h48);
    {lowPowerMode, awakeDone} = 2'h2;
    repeat (5) @(negedge clk);
    cf(ctrlEnable, 1'b0);
    awakeDone = 1'b1;
    repeat (2) @(negedge clk);
    cf(ctrlEnable, 1'b1);
    smp(6'h00, 6'h00, 6'h00);
    smp(6'h00, 6'h00, 6'h00);
    cf(sleepReq, 1'b1);
    smp(6'h0A, 6'h00, 6'h00);
    cf(sleepReq, 1'b0);
    {lowPowerMode, awakeDone} = 2'h0;
    repeat (5) @(negedge clk);
    cf(ctrlEnable, 1'b1);
  endtask
  // Main sequence
  initial begin
    {rst_b, sampleValid, tapEvent, tapSign, lowPowerMode, wakeMode, awakeDone} = 7'h00;
    {fx, fy, fz, rx, ry, rz, tapAxis} = 39'h0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    rc(7'h09, 8'h45);
    rc(7'h0D, 8'h00);
    rc(7'h0C, 8'h00);
    rc(7'h20, 8'h00);
    t_basic();
    t_dur();
    t_latch();
    t_power();
    give_verdict();
  end
endmodule
